// ===== core/fsl_security_top.sv
// fsl_security_top: lock levels, option byte, signatures, loader entry
// assumes flash array reads arrive combinationally for cmd_addr_in
// Function
// - level 1: no lock, encrypted verify if set
// - level 2: block external code reads of flash
// - level 2+: latch access pin at reset
// - level 2+: refuse code and option byte programming; lock programming and mass erase still allowed
// - level 3: no verify, block external SRAM reads
// - level 4: level 3 plus no external execution
// - option bit 3 sets watchdog power-on default
// - other option bits read back as one
// - option readable at FCh and verify-option
// - option byte erased and programmed alone
// - 30h, 31h, 60h return signature bytes
// - loader holds only while entry condition stays
// - loader redirects fetches to internal loader ROM
// - only mass erase resets bank select
// - loader programs flash and security from cmd_in
// - loader measures host baud rate automatically
// - lock state gates access, lock bits readable
// - access pin low fetches externally, high internally
// - loader issues internal flash commands from cmd_in
`timescale 1ns/100ps
module fsl_security_top #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] PART_CODE  = 8'h3c, // arbitrary value
    parameter logic [7:0] EXT_CODE   = 8'h07  // arbitrary value
) (
    input  wire logic                       clk_in,
    input  wire logic                       reset_in,
    input  wire logic                       reset_pin_in,
    input  wire logic                       external_access_pin_n_in,
    input  wire logic                       program_store_strobe_n_in,
    input  wire logic                       rxd0_in,
    input  wire logic                       cmd_valid_in,
    input  wire logic [3:0]                 cmd_in,
    input  wire logic [fsl_pkg::ADDR_W-1:0] cmd_addr_in,
    input  wire logic [7:0]                 cmd_data_in,
    input  wire logic [7:0]                 flash_rdata_in,
    input  wire logic [7:0]                 encrypt_byte_in,
    input  wire logic                       encrypt_set_in,
    input  wire logic                       code_read_instruction_ext_in,
    input  wire logic                       external_data_move_ext_in,
    output logic                            cmd_ack_out,
    output logic                            cmd_refused_out,
    output logic [7:0]                      cmd_rdata_out,
    output logic                            flash_cmd_valid_out,
    output logic [3:0]                      flash_cmd_out,
    output logic [fsl_pkg::ADDR_W-1:0]      flash_addr_out,
    output logic [7:0]                      flash_wdata_out,
    output logic [1:0]                      protect_level_out,
    output logic [2:0]                      lock_bits_out,
    output logic                            code_read_block_out,
    output logic                            sram_read_block_out,
    output logic                            fetch_external_out,
    output logic                            fetch_loader_rom_out,
    output logic                            loader_mode_out,
    output logic                            parallel_mode_out,
    output logic                            wdt_por_disable_out,
    output logic [7:0]                      bank_select_out,
    output logic [fsl_pkg::BAUD_W-1:0]      baud_div_out,
    output logic                            baud_locked_out
);

    fsl_pins_if pins ();

    fsl_sync u_sync (
        .clk_in  (clk_in),
        .pins_in ({rxd0_in, program_store_strobe_n_in,
                   external_access_pin_n_in, reset_pin_in}),
        .pins    (pins.sync_side)
    );

    fsl_pkg::fsl_state_t s_q;
    fsl_pkg::fsl_state_t s_d;
    fsl_pkg::fsl_level_t level;
    fsl_pkg::fsl_cmd_t   cmd;
    logic                loader_cond;
    logic                parallel_cond;
    logic                prog_active;
    logic                ext_access_eff;
    logic [7:0]          opt_view;

    assign cmd = fsl_pkg::fsl_cmd_t'(cmd_in);

    // higher lock bits dominate; lower ones are then don't care
    always_comb begin
        if (!s_q.lock[fsl_pkg::LOCK_THREE]) begin
            level = fsl_pkg::FSL_LVL4;
        end else if (!s_q.lock[fsl_pkg::LOCK_TWO]) begin
            level = fsl_pkg::FSL_LVL3;
        end else if (!s_q.lock[fsl_pkg::LOCK_ONE]) begin
            level = fsl_pkg::FSL_LVL2;
        end else begin
            level = fsl_pkg::FSL_LVL1;
        end
    end

    // entry condition is level-sensitive, so leaving it drops the mode
    assign loader_cond   = pins.reset_pin && !pins.ext_access_n
                           && !pins.store_strobe_n;
    assign parallel_cond = pins.reset_pin && pins.ext_access_n
                           && !pins.store_strobe_n;
    assign prog_active   = s_q.loader || s_q.parallel;

    assign ext_access_eff = (level >= fsl_pkg::FSL_LVL2) ?
                            s_q.ext_latch : pins.ext_access_n;

    assign opt_view = s_q.option | fsl_pkg::OPT_UNDEF;

    always_comb begin
        s_d          = s_q;
        s_d.ack      = 1'b0;
        s_d.refused  = 1'b0;
        s_d.fvalid   = 1'b0;
        s_d.loader   = loader_cond;
        s_d.parallel = parallel_cond;

        // first cycle after release catches the access pin
        if (!s_q.armed) begin
            s_d.armed     = 1'b1;
            s_d.ext_latch = pins.ext_access_n;
        end

        if (cmd_valid_in) begin
            s_d.ack   = 1'b1;
            s_d.rdata = 8'h00;
            if (!prog_active) begin
                s_d.refused = 1'b1;
            end else begin
                case (cmd)
                    fsl_pkg::FSL_CMD_READ_ADDR: begin
                        case (cmd_addr_in[7:0])
                            fsl_pkg::ADDR_MAKER:  s_d.rdata = MAKER_CODE;
                            fsl_pkg::ADDR_PART:   s_d.rdata = PART_CODE;
                            fsl_pkg::ADDR_EXT:    s_d.rdata = EXT_CODE;
                            fsl_pkg::ADDR_OPTION: s_d.rdata = opt_view;
                            default:              s_d.rdata = fsl_pkg::UNMAPPED_READ;
                        endcase
                    end
                    fsl_pkg::FSL_CMD_VERIFY: begin
                        if (level >= fsl_pkg::FSL_LVL3) begin
                            s_d.refused = 1'b1;
                        end else if (encrypt_set_in) begin
                            s_d.rdata = flash_rdata_in ^ encrypt_byte_in;
                        end else begin
                            s_d.rdata = flash_rdata_in;
                        end
                    end
                    fsl_pkg::FSL_CMD_VERIFY_OPT: begin
                        s_d.rdata = opt_view;
                    end
                    fsl_pkg::FSL_CMD_READ_LOCK: begin
                        s_d.rdata = {5'h00, s_q.lock};
                    end
                    fsl_pkg::FSL_CMD_PROG_CODE: begin
                        if (level >= fsl_pkg::FSL_LVL2) begin
                            s_d.refused = 1'b1;
                        end else begin
                            s_d.fvalid = 1'b1;
                            s_d.fcmd   = cmd;
                            s_d.faddr  = cmd_addr_in;
                            s_d.fwdata = cmd_data_in;
                        end
                    end
                    fsl_pkg::FSL_CMD_PROG_OPT: begin
                        if (level >= fsl_pkg::FSL_LVL2) begin
                            s_d.refused = 1'b1;
                        end else begin
                            // flash cells only clear bits until erased
                            s_d.option = s_q.option & cmd_data_in;
                        end
                    end
                    fsl_pkg::FSL_CMD_ERASE_OPT: begin
                        if (level >= fsl_pkg::FSL_LVL2) begin
                            s_d.refused = 1'b1;
                        end else begin
                            s_d.option = fsl_pkg::OPT_ERASED;
                        end
                    end
                    fsl_pkg::FSL_CMD_PROG_LOCK: begin
                        // raising protection is always allowed
                        s_d.lock = s_q.lock & cmd_data_in[2:0];
                    end
                    fsl_pkg::FSL_CMD_MASS_ERASE: begin
                        s_d.lock   = fsl_pkg::LOCK_ERASED;
                        s_d.bank   = fsl_pkg::BANK_DEFAULT;
                        s_d.fvalid = 1'b1;
                        s_d.fcmd   = cmd;
                        s_d.faddr  = '0;
                        s_d.fwdata = 8'hff;
                    end
                    default: begin
                        s_d.refused = 1'b1;
                    end
                endcase
            end
        end

        // auto-baud: width of first start bit gives cycles per bit
        if (!s_q.loader) begin
            s_d.ab = fsl_pkg::FSL_AB_IDLE;
        end else begin
            case (s_q.ab)
                fsl_pkg::FSL_AB_IDLE: begin
                    if (pins.rxd) begin
                        s_d.ab = fsl_pkg::FSL_AB_WAIT;
                    end
                end
                fsl_pkg::FSL_AB_WAIT: begin
                    if (!pins.rxd) begin
                        s_d.ab     = fsl_pkg::FSL_AB_MEASURE;
                        s_d.ab_cnt = {{(fsl_pkg::BAUD_W-1){1'b0}}, 1'b1};
                    end
                end
                fsl_pkg::FSL_AB_MEASURE: begin
                    if (!pins.rxd) begin
                        if (s_q.ab_cnt != '1) begin
                            s_d.ab_cnt = s_q.ab_cnt + 1'b1;
                        end
                    end else if (s_q.ab_cnt >= fsl_pkg::AB_MIN_COUNT) begin
                        s_d.baud_div = s_q.ab_cnt;
                        s_d.ab       = fsl_pkg::FSL_AB_DONE;
                    end else begin
                        // glitch, not a start bit
                        s_d.ab = fsl_pkg::FSL_AB_WAIT;
                    end
                end
                fsl_pkg::FSL_AB_DONE: begin
                    s_d.ab = fsl_pkg::FSL_AB_DONE;
                end
                default: begin
                    s_d.ab = fsl_pkg::FSL_AB_IDLE;
                end
            endcase
        end
    end

    // flash-held state starts erased: reset_in stands for a blank part
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q          <= '0;
            s_q.lock     <= fsl_pkg::LOCK_ERASED;
            s_q.option   <= fsl_pkg::OPT_ERASED;
            s_q.bank     <= fsl_pkg::BANK_DEFAULT;
            s_q.ext_latch<= 1'b1;
            s_q.fcmd     <= fsl_pkg::FSL_CMD_NOP;
            s_q.ab       <= fsl_pkg::FSL_AB_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmd_ack_out          = s_q.ack;
    assign cmd_refused_out      = s_q.refused;
    assign cmd_rdata_out        = s_q.rdata;
    assign flash_cmd_valid_out  = s_q.fvalid;
    assign flash_cmd_out        = s_q.fcmd;
    assign flash_addr_out       = s_q.faddr;
    assign flash_wdata_out      = s_q.fwdata;
    assign protect_level_out    = level;
    assign lock_bits_out        = s_q.lock;
    assign code_read_block_out  = code_read_instruction_ext_in
                                  && (level >= fsl_pkg::FSL_LVL2);
    assign sram_read_block_out  = external_data_move_ext_in
                                  && (level >= fsl_pkg::FSL_LVL3);
    assign fetch_external_out   = !ext_access_eff && !s_q.loader
                                  && (level != fsl_pkg::FSL_LVL4);
    assign fetch_loader_rom_out = s_q.loader;
    assign loader_mode_out      = s_q.loader;
    assign parallel_mode_out    = s_q.parallel;
    assign wdt_por_disable_out  = s_q.option[fsl_pkg::OPT_WDT_BIT];
    assign bank_select_out      = s_q.bank;
    assign baud_div_out         = s_q.baud_div;
    assign baud_locked_out      = (s_q.ab == fsl_pkg::FSL_AB_DONE);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_level_from_lock: assert property (!lock_bits_out[2]
        |-> protect_level_out == 2'h3)
        else $error("lock three not giving level four");
    a_code_read_gate: assert property ((level >= fsl_pkg::FSL_LVL2)
        && code_read_instruction_ext_in |-> code_read_block_out)
        else $error("external code read not blocked");
    a_pin_latched: assert property (s_q.armed && $past(s_q.armed)
        && (level >= fsl_pkg::FSL_LVL2) && ($past(level) == level)
        |-> $stable(ext_access_eff))
        else $error("access pin followed after latch");
    a_prog_refused: assert property (cmd_valid_in && prog_active
        && cmd == fsl_pkg::FSL_CMD_PROG_CODE && level >= fsl_pkg::FSL_LVL2
        |=> cmd_refused_out && !flash_cmd_valid_out)
        else $error("programming allowed while locked");
    a_verify_refused: assert property (cmd_valid_in && prog_active
        && cmd == fsl_pkg::FSL_CMD_VERIFY && level >= fsl_pkg::FSL_LVL3
        |=> cmd_ack_out && cmd_refused_out)
        else $error("verify allowed at level three");
    a_no_ext_exec: assert property (protect_level_out == 2'h3
        |-> !fetch_external_out)
        else $error("external fetch at level four");
    a_wdt_bit: assert property (cmd_valid_in && prog_active
        && cmd == fsl_pkg::FSL_CMD_VERIFY_OPT
        |=> cmd_rdata_out[3] == wdt_por_disable_out
            && (cmd_rdata_out & 8'hf7) == 8'hf7)
        else $error("option read back wrong");
    a_signature: assert property (cmd_valid_in && prog_active
        && cmd == fsl_pkg::FSL_CMD_READ_ADDR && cmd_addr_in[7:0] == 8'h30
        |=> cmd_rdata_out == MAKER_CODE)
        else $error("maker byte wrong");
    a_loader_exit: assert property (loader_mode_out && !pins.reset_pin
        |=> !loader_mode_out)
        else $error("loader held after condition removed");
    a_loader_fetch: assert property (loader_mode_out
        |-> fetch_loader_rom_out && !fetch_external_out)
        else $error("loader not fetching from rom");
    a_bank_stable: assert property (!(cmd_valid_in && prog_active
        && cmd == fsl_pkg::FSL_CMD_MASS_ERASE) |=> $stable(bank_select_out))
        else $error("bank select changed without erase");
    a_baud_measure: assert property ($rose(baud_locked_out)
        |-> baud_div_out >= 16'h0004)
        else $error("baud locked on a glitch");
    a_mass_erase: assert property (cmd_valid_in && prog_active
        && cmd == fsl_pkg::FSL_CMD_MASS_ERASE
        |=> flash_cmd_valid_out && lock_bits_out == fsl_pkg::LOCK_ERASED
            && bank_select_out == fsl_pkg::BANK_DEFAULT)
        else $error("mass erase left lock or bank set");
    a_opt_locked: assert property (cmd_valid_in && prog_active
        && (cmd == fsl_pkg::FSL_CMD_PROG_OPT || cmd == fsl_pkg::FSL_CMD_ERASE_OPT)
        && level >= fsl_pkg::FSL_LVL2 |=> cmd_refused_out && $stable(wdt_por_disable_out))
        else $error("option changed while locked");
    a_enc_verify: assert property (cmd_valid_in && prog_active && encrypt_set_in
        && cmd == fsl_pkg::FSL_CMD_VERIFY && level < fsl_pkg::FSL_LVL3
        |=> cmd_rdata_out == ($past(flash_rdata_in) ^ $past(encrypt_byte_in)))
        else $error("verify data not encrypted");
    a_idle_refused: assert property (cmd_valid_in && !prog_active
        |=> cmd_ack_out && cmd_refused_out && !flash_cmd_valid_out)
        else $error("command served outside programming modes");

endmodule : fsl_security_top

// ===== core/fsl_pkg.sv
// fsl_pkg: constants, types and state layout of the flash security block
// assumes one 50 MHz clock and a synchronous active-high reset
package fsl_pkg;

    localparam int          SYNC_STAGES   = 2;
    localparam int          BAUD_W        = 16;
    localparam int          ADDR_W        = 16;

    // programming-mode read map
    localparam logic [7:0]  ADDR_MAKER    = 8'h30;
    localparam logic [7:0]  ADDR_PART     = 8'h31;
    localparam logic [7:0]  ADDR_EXT      = 8'h60;
    localparam logic [7:0]  ADDR_OPTION   = 8'hfc;

    // option byte layout
    localparam int          OPT_WDT_BIT   = 3;
    localparam logic [7:0]  OPT_ERASED    = 8'hff;
    localparam logic [7:0]  OPT_UNDEF     = 8'hf7;
    localparam logic [7:0]  UNMAPPED_READ = 8'hff;

    // lock bits, 0 = programmed
    localparam int          LOCK_ONE      = 0;
    localparam int          LOCK_TWO      = 1;
    localparam int          LOCK_THREE    = 2;
    localparam logic [2:0]  LOCK_ERASED   = 3'h7;

    localparam logic [7:0]  BANK_DEFAULT  = 8'h00;
    localparam logic [BAUD_W-1:0] AB_MIN_COUNT = 16'h0004;

    typedef enum logic [1:0] {
        FSL_LVL1 = 2'h0,
        FSL_LVL2 = 2'h1,
        FSL_LVL3 = 2'h2,
        FSL_LVL4 = 2'h3
    } fsl_level_t;

    typedef enum logic [3:0] {
        FSL_CMD_NOP        = 4'h0,
        FSL_CMD_READ_ADDR  = 4'h1,
        FSL_CMD_VERIFY     = 4'h2,
        FSL_CMD_VERIFY_OPT = 4'h3,
        FSL_CMD_READ_LOCK  = 4'h4,
        FSL_CMD_PROG_CODE  = 4'h5,
        FSL_CMD_PROG_OPT   = 4'h6,
        FSL_CMD_ERASE_OPT  = 4'h7,
        FSL_CMD_PROG_LOCK  = 4'h8,
        FSL_CMD_MASS_ERASE = 4'h9
    } fsl_cmd_t;

    typedef enum logic [1:0] {
        FSL_AB_IDLE    = 2'b00,
        FSL_AB_WAIT    = 2'b01,
        FSL_AB_MEASURE = 2'b11,
        FSL_AB_DONE    = 2'b10
    } fsl_ab_t;

    typedef struct packed {
        logic [2:0]        lock;
        logic [7:0]        option;
        logic [7:0]        bank;
        logic              armed;
        logic              ext_latch;
        logic              loader;
        logic              parallel;
        logic              ack;
        logic              refused;
        logic [7:0]        rdata;
        logic              fvalid;
        fsl_cmd_t          fcmd;
        logic [ADDR_W-1:0] faddr;
        logic [7:0]        fwdata;
        fsl_ab_t           ab;
        logic [BAUD_W-1:0] ab_cnt;
        logic [BAUD_W-1:0] baud_div;
    } fsl_state_t;

endpackage : fsl_pkg

// ===== core/fsl_pins_if.sv
// fsl_pins_if: synchronised entry pins and serial receive line
// assumes the synchroniser drives it and the core only reads it
`timescale 1ns/100ps
interface fsl_pins_if;
    logic reset_pin;
    logic ext_access_n;
    logic store_strobe_n;
    logic rxd;

    modport sync_side (output reset_pin, output ext_access_n,
                       output store_strobe_n, output rxd);
    modport core_side (input reset_pin, input ext_access_n,
                       input store_strobe_n, input rxd);
endinterface : fsl_pins_if

// ===== core/fsl_sync.sv
// fsl_sync: two-stage synchroniser for the four asynchronous pins
// assumes pins may change at any time relative to clk_in
`timescale 1ns/100ps
module fsl_sync (
    input  wire logic       clk_in,
    input  wire logic [3:0] pins_in,
    fsl_pins_if.sync_side   pins
);
    // no reset: the chain must keep shifting while reset is held
    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] stable;
    } fsl_sync_t;

    fsl_sync_t s_q;
    fsl_sync_t s_d;

    always_comb begin
        s_d.meta   = pins_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk_in) begin
        s_q <= s_d;
    end

    assign pins.reset_pin      = s_q.stable[0];
    assign pins.ext_access_n   = s_q.stable[1];
    assign pins.store_strobe_n = s_q.stable[2];
    assign pins.rxd            = s_q.stable[3];
endmodule : fsl_sync

// ===== tb/fsl_host_model.sv
// fsl_host_model: host on the far side driving entry pins and serial line
// assumes the bench calls its tasks; pins change on the falling edge
`timescale 1ns/100ps
module fsl_host_model (
    input  wire logic clk_in,
    output logic      reset_pin_out,
    output logic      access_n_out,
    output logic      strobe_n_out,
    output logic      rxd_out
);
    // idle: no mode requested, serial line high
    initial begin
        reset_pin_out = 1'b0;
        access_n_out  = 1'b1;
        strobe_n_out  = 1'b1;
        rxd_out       = 1'b1;
    end

    task set_pins(input logic rp, input logic acc_n, input logic str_n);
        @(negedge clk_in);
        reset_pin_out = rp;
        access_n_out  = acc_n;
        strobe_n_out  = str_n;
    endtask : set_pins

    // one low start pulse of n cycles for the rate detector
    task baud_pulse(input int n);
        @(negedge clk_in);
        rxd_out = 1'b0;
        repeat (n) @(negedge clk_in);
        rxd_out = 1'b1;
    endtask : baud_pulse
endmodule : fsl_host_model

// ===== tb/tb_flash_security_and_loader_entry.sv
// tb_flash_security_and_loader_entry: self-checking bench for fsl_security_top
// assumes the host model owns the entry pins and the serial line
`timescale 1ns/100ps
module tb_flash_security_and_loader_entry;
    logic clk_in = 1'b0, reset_in = 1'b1, cmd_valid_in = 1'b0, encrypt_set_in = 1'b0;
    logic cri_in = 1'b0, xdm_in = 1'b0, ack, refused, fvalid, loader, par, wdt, locked, fext, rom;
    logic [3:0] cmd_in = 4'h0, fcmd;
    logic [15:0] addr_in = 16'h0000, faddr, bdiv;
    logic [7:0] data_in = 8'h00, frd_in = 8'h00, key_in = 8'h00, rdata, fwd, bank;
    logic [1:0] lvl;
    logic [2:0] lockb;
    logic rp, acc_n, str_n, rxd, crb, srb, fv_seen;
    int err_count = 0, cmp_count = 0;

    always #10 clk_in = ~clk_in;

    fsl_host_model host (.clk_in(clk_in), .reset_pin_out(rp), .access_n_out(acc_n),
                         .strobe_n_out(str_n), .rxd_out(rxd));
    fsl_security_top dut (.clk_in(clk_in), .reset_in(reset_in), .reset_pin_in(rp),
        .external_access_pin_n_in(acc_n), .program_store_strobe_n_in(str_n), .rxd0_in(rxd),
        .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_addr_in(addr_in),
        .cmd_data_in(data_in), .flash_rdata_in(frd_in), .encrypt_byte_in(key_in),
        .encrypt_set_in(encrypt_set_in), .code_read_instruction_ext_in(cri_in),
        .external_data_move_ext_in(xdm_in), .cmd_ack_out(ack), .cmd_refused_out(refused),
        .cmd_rdata_out(rdata), .flash_cmd_valid_out(fvalid), .flash_cmd_out(fcmd),
        .flash_addr_out(faddr), .flash_wdata_out(fwd), .protect_level_out(lvl),
        .lock_bits_out(lockb), .code_read_block_out(crb), .sram_read_block_out(srb),
        .fetch_external_out(fext), .fetch_loader_rom_out(rom), .loader_mode_out(loader),
        .parallel_mode_out(par), .wdt_por_disable_out(wdt), .bank_select_out(bank),
        .baud_div_out(bdiv), .baud_locked_out(locked));

    task stop_test;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk

    // one request, answer awaited under a bound; valid lasts one cycle
    task do_cmd(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d,
                input logic ref_exp);
        int n;
        @(negedge clk_in);
        cmd_valid_in = 1'b1;
        cmd_in = c;
        addr_in = a;
        data_in = d;
        @(negedge clk_in);
        cmd_valid_in = 1'b0;
        for (n = 0; n < 4 && ack !== 1'b1; n++) @(negedge clk_in);
        if (n == 4) begin
            err_count++;
            stop_test();
        end
        fv_seen = fvalid;
        chk("refused", {15'h0000, ref_exp}, {15'h0000, refused});
    endtask : do_cmd

    // mode outputs follow pins after two sync stages and one register
    task set_mode(input logic rp_v, input logic a_n, input logic s_n, input logic ld);
        host.set_pins(rp_v, a_n, s_n);
        repeat (2) @(negedge clk_in);
        chk("mode early", {15'h0000, ~ld}, {15'h0000, loader});
        @(negedge clk_in);
        chk("loader", {15'h0000, ld}, {15'h0000, loader});
    endtask : set_mode

    task test_reset;
        chk("level", 16'h0000, {14'h0000, lvl});
        chk("lock", 16'h0007, {13'h0000, lockb});
        chk("wdt", 16'h0001, {15'h0000, wdt});
        chk("bank", 16'h0000, {8'h00, bank});
        chk("fetch int", 16'h0000, {15'h0000, fext});
        host.set_pins(1'b0, 1'b0, 1'b1);
        repeat (3) @(negedge clk_in);
        chk("fetch ext", 16'h0001, {15'h0000, fext});
        do_cmd(4'h1, 16'h0030, 8'h00, 1'b1);
        $display("test reset done");
    endtask : test_reset

    task test_loader_regs;
        set_mode(1'b1, 1'b0, 1'b0, 1'b1);
        chk("rom fetch", 16'h0001, {15'h0000, rom});
        do_cmd(4'h1, 16'h0030, 8'h00, 1'b0);
        chk("maker", 16'h005a, {8'h00, rdata});
        do_cmd(4'h1, 16'h0031, 8'h00, 1'b0);
        chk("part", 16'h003c, {8'h00, rdata});
        do_cmd(4'h1, 16'h0060, 8'h00, 1'b0);
        chk("ext", 16'h0007, {8'h00, rdata});
        do_cmd(4'h1, 16'h00fc, 8'h00, 1'b0);
        chk("option", 16'h00ff, {8'h00, rdata});
        do_cmd(4'h6, 16'h00fc, 8'h00, 1'b0);
        do_cmd(4'h3, 16'h0000, 8'h00, 1'b0);
        chk("option prog", 16'h00f7, {8'h00, rdata});
        chk("wdt on", 16'h0000, {15'h0000, wdt});
        do_cmd(4'h7, 16'h00fc, 8'h00, 1'b0);
        chk("wdt off", 16'h0001, {15'h0000, wdt});
        frd_in = 8'h5c;
        do_cmd(4'h2, 16'h0040, 8'h00, 1'b0);
        chk("verify", 16'h005c, {8'h00, rdata});
        do_cmd(4'h0, 16'h0000, 8'h00, 1'b1);
        do_cmd(4'hf, 16'h0000, 8'h00, 1'b1);
        do_cmd(4'h5, 16'h1234, 8'h5c, 1'b0);
        chk("fcmd", 16'h855c, {fv_seen, 3'h0, fcmd, fwd});
        chk("faddr", 16'h1234, faddr);
        $display("test loader regs done");
    endtask : test_loader_regs

    task test_baud;
        int n;
        host.baud_pulse(12);
        for (n = 0; n < 8 && locked !== 1'b1; n++) @(negedge clk_in);
        if (n == 8) begin
            err_count++;
            stop_test();
        end
        chk("baud lock", 16'h0001, {15'h0000, locked});
        chk("baud div", 16'h000c, bdiv);
        $display("test baud done");
    endtask : test_baud

    task test_locks;
        cri_in = 1'b1;
        xdm_in = 1'b1;
        chk("code blk l1", 16'h0000, {15'h0000, crb});
        do_cmd(4'h8, 16'h0000, 8'h06, 1'b0);
        chk("level2", 16'h0001, {14'h0000, lvl});
        chk("code blk", 16'h0001, {15'h0000, crb});
        chk("sram blk l2", 16'h0000, {15'h0000, srb});
        do_cmd(4'h5, 16'h0010, 8'h11, 1'b1);
        do_cmd(4'h6, 16'h00fc, 8'h00, 1'b1);
        encrypt_set_in = 1'b1;
        key_in = 8'h3c;
        frd_in = 8'ha5;
        do_cmd(4'h2, 16'h0020, 8'h00, 1'b0);
        chk("verify enc", 16'h0099, {8'h00, rdata});
        do_cmd(4'h8, 16'h0000, 8'h05, 1'b0);
        chk("level3", 16'h0002, {14'h0000, lvl});
        chk("sram blk", 16'h0001, {15'h0000, srb});
        do_cmd(4'h2, 16'h0020, 8'h00, 1'b1);
        do_cmd(4'h4, 16'h0000, 8'h00, 1'b0);
        chk("read lock", 16'h0004, {8'h00, rdata});
        do_cmd(4'h8, 16'h0000, 8'h03, 1'b0);
        chk("level4", 16'h0003, {14'h0000, lvl});
        set_mode(1'b0, 1'b0, 1'b1, 1'b0);
        chk("no ext exec", 16'h0000, {15'h0000, fext});
        do_cmd(4'h4, 16'h0000, 8'h00, 1'b1);
        host.set_pins(1'b1, 1'b1, 1'b0);
        repeat (3) @(negedge clk_in);
        chk("parallel", 16'h0001, {15'h0000, par});
        do_cmd(4'h9, 16'h0000, 8'h00, 1'b0);
        chk("erased", 16'h0700, {5'h00, lockb, bank});
        chk("erase cmd", 16'h89ff, {fv_seen, 3'h0, fcmd, fwd});
        chk("level1", 16'h0000, {14'h0000, lvl});
        $display("test locks done");
    endtask : test_locks

    initial begin
        repeat (20) @(negedge clk_in);
        reset_in = 1'b0;
        test_reset();
        test_loader_regs();
        test_baud();
        test_locks();
        stop_test();
    end
endmodule : tb_flash_security_and_loader_entry
